// ==== common/afcr_consts.vh ====
// constants for the adc front end configuration and reference detect block
`ifndef AFCR_CONSTS_VH
`define AFCR_CONSTS_VH

// ****************************************
// register byte offsets
// ****************************************
`define AFCR_OFF_CONFIG      12'h000
`define AFCR_OFF_STATUS      12'h004
`define AFCR_OFF_IRQ_MASK    12'h008
`define AFCR_OFF_DATA        12'h00C
`define AFCR_OFF_OFFSET_COEF 12'h010
`define AFCR_OFF_FULL_COEF   12'h014
`define AFCR_OFF_ROUTE       12'h018

// ****************************************
// config register fields
// ****************************************
`define AFCR_CFG_CH_LSB      0
`define AFCR_CFG_CH_MSB      7
`define AFCR_CFG_PSEUDO      8
`define AFCR_CFG_BUF         9
`define AFCR_CFG_GAIN_LSB    10
`define AFCR_CFG_GAIN_MSB    12
`define AFCR_CFG_REFERENCE_SELECT      13
`define AFCR_CFG_REFERENCE_DETECT_ENABLE      14
`define AFCR_CFG_UNIPOLAR    15
`define AFCR_CFG_BURN        16
`define AFCR_CFG_RESET       32'h00000000

// ****************************************
// status / interrupt bits
// ****************************************
`define AFCR_ST_REF_MISSING  0
`define AFCR_ST_ERR          1
`define AFCR_ST_DATA_READY   2
`define AFCR_ST_CAL_DONE     3
`define AFCR_ST_W            4

// ****************************************
// coefficient resets and codes
// ****************************************
`define AFCR_OFFSET_RESET    24'h800000
`define AFCR_FULL_RESET      24'h500000
`define AFCR_ALL_ONES        24'hFFFFFF
`define AFCR_MSB_ONLY        24'h800000
`define AFCR_GAIN_W          8

`endif

// ==== src/afcr_gain_lut.v ====
// gain select decode table with registered output
`timescale 1ns/1ps
module afcr_gain_lut (
  input  wire       sys_clk,
  input  wire       nrst,
  input  wire [2:0] gain_select_field,
  output reg  [7:0] gain_value_r,
  output reg        gain_valid_r
);
  always @(posedge sys_clk) begin
    if (!nrst) begin
      gain_value_r <= 8'h01;
      gain_valid_r <= 1'b1;
    end else begin
      gain_valid_r <= 1'b1;
      case (gain_select_field)
        3'h0: gain_value_r <= 8'h01;
        3'h3: gain_value_r <= 8'h08;
        3'h4: gain_value_r <= 8'h10;
        3'h5: gain_value_r <= 8'h20;
        3'h6: gain_value_r <= 8'h40;
        3'h7: gain_value_r <= 8'h80;
        // reserved codes fall back to unity gain and are flagged
        default: begin
          gain_value_r <= 8'h01;
          gain_valid_r <= 1'b0;
        end
      endcase
    end
  end
endmodule // afcr_gain_lut

// ==== src/afcr_top.v ====
// adc front end configuration, reference detect and result coding
// Function
// RULE1: any of sixteen pins may be positive or negative; common pin negative only
// RULE2: channel from eight-bit field plus pseudo bit; pairs, singles or mixed
// RULE3: buffer enable bit routes inputs through buffer, else bypass
// RULE4: three-bit gain select picks gain 1, 8, 16, 32, 64 or 128
// RULE5: reference select picks pair two, which then stops being outputs
// RULE6: reference checking works only while detect enable is set
// RULE7: missing flag set below low threshold, cleared above high threshold
// RULE8: during conversions a missing reference forces an all-ones result
// RULE9: missing reference during calibration keeps coefficient and sets error
// RULE10: polarity bit selects unipolar or bipolar coding
// RULE11: unipolar results are straight binary
// RULE12: bipolar results are 24-bit offset binary
// RULE13: both burnout sources switch together per burnout enable bit
// RULE14: host need check missing flag only when result is all ones
// RULE15: host should read error flag after each calibration
// RULE16: offset coefficient resets to midscale, updated by clean zero calibration
// RULE17: between thresholds the missing flag holds its value
// RULE18: the clamp applies to the stored data word
`timescale 1ns/1ps
`include "afcr_consts.vh"
module afcr_top #(
  parameter DATA_W = 24
) (
  input  wire              sys_clk,
  input  wire              nrst,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              ref_below_low,
  input  wire              ref_above_high,
  input  wire              conv_valid,
  input  wire [DATA_W-1:0] conv_unipolar_code,
  input  wire              cal_valid,
  input  wire              cal_full_scale,
  input  wire [DATA_W-1:0] cal_coef,
  output reg  [3:0]        pos_pin_sel,
  output reg  [3:0]        neg_pin_sel,
  output reg               neg_common_sel,
  output reg               buffer_on,
  output reg  [7:0]        gain_value,
  output reg               ref_pair_two_as_ref,
  output reg               ref_pair_two_gpo_en,
  output reg               burnout_src_on,
  output reg               burnout_sink_on,
  output reg  [DATA_W-1:0] offset_coef,
  output reg  [DATA_W-1:0] full_coef,
  output wire              irq
);

  // ****************************************
  // registers
  // ****************************************
  reg  [31:0]            config_r;
  reg  [31:0]            config_nxt;
  reg  [`AFCR_ST_W-1:0]  status_r;
  reg  [`AFCR_ST_W-1:0]  status_nxt;
  reg  [`AFCR_ST_W-1:0]  mask_r;
  reg  [DATA_W-1:0]      data_r;
  reg                    ref_missing_r;
  reg                    ref_missing_nxt;
  reg  [7:0]             gpo_r;
  wire [7:0]             gain_lut;
  wire                   gain_ok;
  wire                   wr_en;
  wire                   rd_en;
  wire                   addr_ok;
  wire [2:0]             gain_select_field;
  wire [7:0]             channel_select_field;
  wire                   wr_config;
  wire                   wr_mask;
  wire                   wr_route;
  wire                   wr_offset;
  wire                   wr_full;
  wire                   rd_status;

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & penable & ~pwrite;
  assign pready  = 1'b1;
  assign addr_ok = is_mapped(paddr);
  assign pslverr = psel & penable & ~addr_ok;
  assign gain_select_field    = config_r[`AFCR_CFG_GAIN_MSB:`AFCR_CFG_GAIN_LSB];
  assign channel_select_field = config_r[`AFCR_CFG_CH_MSB:`AFCR_CFG_CH_LSB];

  // address decode used by the error answer; the read mux decodes paddr on its own
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `AFCR_OFF_CONFIG) || (a == `AFCR_OFF_STATUS) ||
                  (a == `AFCR_OFF_IRQ_MASK) || (a == `AFCR_OFF_DATA) ||
                  (a == `AFCR_OFF_OFFSET_COEF) || (a == `AFCR_OFF_FULL_COEF) ||
                  (a == `AFCR_OFF_ROUTE);
    end
  endfunction

  // ****************************************
  // register strobes
  // ****************************************
  function reg_hit;
    input [11:0] a;
    input [11:0] off;
    begin
      reg_hit = (a == off);
    end
  endfunction

  assign wr_config = wr_en & reg_hit(paddr, `AFCR_OFF_CONFIG);
  assign wr_mask   = wr_en & reg_hit(paddr, `AFCR_OFF_IRQ_MASK);
  assign wr_route  = wr_en & reg_hit(paddr, `AFCR_OFF_ROUTE);
  assign wr_offset = wr_en & reg_hit(paddr, `AFCR_OFF_OFFSET_COEF);
  assign wr_full   = wr_en & reg_hit(paddr, `AFCR_OFF_FULL_COEF);
  // the read strobe clears the sticky status bits
  assign rd_status = rd_en & reg_hit(paddr, `AFCR_OFF_STATUS);

  // ****************************************
  // gain decode
  // ****************************************
  // RULE4: gain table
  afcr_gain_lut u_gain (
    .sys_clk           (sys_clk),
    .nrst              (nrst),
    .gain_select_field (gain_select_field),
    .gain_value_r      (gain_lut),
    .gain_valid_r      (gain_ok)
  );

  // ****************************************
  // reference detect with hysteresis
  // ****************************************
  always @* begin
    // RULE17: hold between thresholds
    ref_missing_nxt = ref_missing_r;
    // RULE6: detect gated by enable
    if (!config_r[`AFCR_CFG_REFERENCE_DETECT_ENABLE]) begin
      ref_missing_nxt = 1'b0;
    // RULE7: set below low threshold
    end else if (ref_below_low) begin
      ref_missing_nxt = 1'b1;
    end else if (ref_above_high) begin
      ref_missing_nxt = 1'b0;
    end
  end

  // ****************************************
  // config and status next values
  // ****************************************
  always @* begin
    config_nxt = config_r;
    if (wr_config) begin
      config_nxt = pwdata;
    end
  end

  always @* begin
    status_nxt = status_r;
    // read of status clears; sets below win over the clear
    if (rd_status) begin
      status_nxt = {`AFCR_ST_W{1'b0}};
    end
    if (ref_missing_nxt && !ref_missing_r) begin
      status_nxt[`AFCR_ST_REF_MISSING] = 1'b1;
    end
    if (conv_valid) begin
      status_nxt[`AFCR_ST_DATA_READY] = 1'b1;
    end
    if (cal_valid) begin
      status_nxt[`AFCR_ST_CAL_DONE] = 1'b1;
    end
    // RULE9: error on inhibited calibration
    if (cal_valid && ref_missing_r) begin
      status_nxt[`AFCR_ST_ERR] = 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (!nrst) begin
      config_r      <= `AFCR_CFG_RESET;
      status_r      <= {`AFCR_ST_W{1'b0}};
      mask_r        <= {`AFCR_ST_W{1'b0}};
      ref_missing_r <= 1'b0;
      gpo_r         <= 8'h00;
    end else begin
      config_r      <= config_nxt;
      status_r      <= status_nxt;
      ref_missing_r <= ref_missing_nxt;
      if (wr_mask) begin
        mask_r <= pwdata[`AFCR_ST_W-1:0];
      end
      if (wr_route) begin
        gpo_r <= pwdata[7:0];
      end
    end
  end

  // ****************************************
  // interrupt
  // ****************************************
  // level output, held until a status read clears the unmasked bits
  assign irq = |(status_r & mask_r);

  // ****************************************
  // result coding and clamp
  // ****************************************
  // the modulator hands over a straight binary code; bipolar flips the top bit
  always @(posedge sys_clk) begin
    if (!nrst) begin
      data_r <= {DATA_W{1'b0}};
    end else if (conv_valid) begin
      // RULE8: clamp on missing reference
      // RULE18: clamp lands in data register
      if (ref_missing_r) begin
        data_r <= {DATA_W{1'b1}};
      // RULE11: straight binary
      end else if (config_r[`AFCR_CFG_UNIPOLAR]) begin
        data_r <= conv_unipolar_code;
      // RULE10: polarity select
      // RULE12: offset binary
      end else begin
        data_r <= conv_unipolar_code ^ {1'b1, {(DATA_W-1){1'b0}}};
      end
    end
  end

  // ****************************************
  // calibration coefficients
  // ****************************************
  always @(posedge sys_clk) begin
    if (!nrst) begin
      // RULE16: midscale offset reset
      offset_coef <= `AFCR_OFFSET_RESET;
      full_coef   <= `AFCR_FULL_RESET;
    end else begin
      // a bus write in a calibration cycle is dropped so an inhibited result keeps both words
      // RULE9: update inhibited without reference
      // RULE16: zero calibration writes offset
      if (cal_valid && !ref_missing_r && !cal_full_scale) begin
        offset_coef <= cal_coef;
      end else if (wr_offset && !cal_valid) begin
        offset_coef <= pwdata[DATA_W-1:0];
      end
      if (cal_valid && !ref_missing_r && cal_full_scale) begin
        full_coef <= cal_coef;
      end else if (wr_full && !cal_valid) begin
        full_coef <= pwdata[DATA_W-1:0];
      end
    end
  end

  // ****************************************
  // front end routing outputs
  // ****************************************
  always @(posedge sys_clk) begin
    if (!nrst) begin
      pos_pin_sel         <= 4'h0;
      neg_pin_sel         <= 4'h0;
      neg_common_sel      <= 1'b0;
      buffer_on           <= 1'b0;
      gain_value          <= 8'h01;
      ref_pair_two_as_ref <= 1'b0;
      ref_pair_two_gpo_en <= 1'b0;
      burnout_src_on      <= 1'b0;
      burnout_sink_on     <= 1'b0;
    end else begin
      // RULE1: any pin positive or negative
      // RULE2: field plus pseudo bit
      pos_pin_sel    <= channel_select_field[7:4];
      neg_pin_sel    <= channel_select_field[3:0];
      // common pin only ever reaches the negative side
      neg_common_sel <= config_r[`AFCR_CFG_PSEUDO];
      // RULE3: buffer route
      buffer_on      <= config_r[`AFCR_CFG_BUF];
      gain_value     <= gain_lut;
      // RULE5: pair two as reference
      ref_pair_two_as_ref <= config_r[`AFCR_CFG_REFERENCE_SELECT];
      ref_pair_two_gpo_en <= ~config_r[`AFCR_CFG_REFERENCE_SELECT] & gpo_r[0];
      // RULE13: both sources together
      burnout_src_on  <= config_r[`AFCR_CFG_BURN];
      burnout_sink_on <= config_r[`AFCR_CFG_BURN];
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always @* begin
    prdata = 32'h00000000;
    case (paddr)
      `AFCR_OFF_CONFIG:      prdata = config_r;
      `AFCR_OFF_STATUS:      prdata = {{(32-`AFCR_ST_W){1'b0}}, status_r[`AFCR_ST_W-1:1],
                                       ref_missing_r};
      `AFCR_OFF_IRQ_MASK:    prdata = {{(32-`AFCR_ST_W){1'b0}}, mask_r};
      `AFCR_OFF_DATA:        prdata = {{(32-DATA_W){1'b0}}, data_r};
      `AFCR_OFF_OFFSET_COEF: prdata = {{(32-DATA_W){1'b0}}, offset_coef};
      `AFCR_OFF_FULL_COEF:   prdata = {{(32-DATA_W){1'b0}}, full_coef};
      `AFCR_OFF_ROUTE:       prdata = {15'h0000, gain_ok, gain_value, gpo_r};
      default:               prdata = 32'h00000000;
    endcase
  end
endmodule // afcr_top

// ==== tb/afcr_props.sv ====
// assertion checker for the afcr block ports
`timescale 1ns/1ps
module afcr_props #(
  parameter DATA_W = 24
) (
  input wire              sys_clk,
  input wire              nrst,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [11:0]       paddr,
  input wire [31:0]       pwdata,
  input wire              ref_below_low,
  input wire              ref_above_high,
  input wire              cal_valid,
  input wire              cal_full_scale,
  input wire [DATA_W-1:0] cal_coef,
  input wire [3:0]        pos_pin_sel,
  input wire [3:0]        neg_pin_sel,
  input wire              neg_common_sel,
  input wire              buffer_on,
  input wire [7:0]        gain_value,
  input wire              ref_pair_two_as_ref,
  input wire              ref_pair_two_gpo_en,
  input wire              burnout_src_on,
  input wire              burnout_sink_on,
  input wire [DATA_W-1:0] offset_coef,
  input wire [DATA_W-1:0] full_coef,
  input wire              irq
);
  // ****
  // shadow of detect enable, missing flag and mask
  // ****
  wire wr = psel && penable && pwrite;
  wire cw = wr && paddr == 12'h000;
  reg  det_r;
  reg  flag_r;
  reg  mask0_r;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      det_r   <= 1'b0;
      flag_r  <= 1'b0;
      mask0_r <= 1'b1;
    end else begin
      if (cw) det_r <= pwdata[14];
      if (wr && paddr == 12'h008) mask0_r <= (pwdata[3:0] == 4'h0);
      flag_r <= det_r & (ref_below_low | (flag_r & !ref_above_high));
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_PINS: assert property (cw |-> ##2 pos_pin_sel == $past(pwdata[7:4], 2) &&
    neg_pin_sel == $past(pwdata[3:0], 2) && neg_common_sel == $past(pwdata[8], 2))
    else $error("pin select differs from config");
  AST_BUF: assert property (cw |-> ##2 buffer_on == $past(pwdata[9], 2))
    else $error("buffer enable differs");
  AST_GAIN: assert property (cw && pwdata[12:10] == 3'h7 |-> ##3 gain_value == 8'h80)
    else $error("top gain code not 128");
  AST_REFERENCE_SELECT: assert property (cw |-> ##2 ref_pair_two_as_ref == $past(pwdata[13], 2))
    else $error("reference select differs");
  AST_GPO: assert property (ref_pair_two_as_ref |-> !ref_pair_two_gpo_en)
    else $error("pair two both reference and output");
  AST_BURN: assert property (burnout_src_on == burnout_sink_on)
    else $error("burnout sources split");
  AST_CAL_KEEP: assert property (cal_valid && flag_r |=>
    $stable(offset_coef) && $stable(full_coef))
    else $error("coefficient loaded without reference");
  AST_OFF_LOAD: assert property (cal_valid && !cal_full_scale && !flag_r |=>
    offset_coef == $past(cal_coef))
    else $error("offset coefficient not loaded");
  AST_IRQ_MASK: assert property (mask0_r |-> !irq)
    else $error("interrupt with all sources masked");
  cover property (cal_valid && flag_r);
  cover property (cw && pwdata[14]);
  cover property ($rose(irq));
endmodule // afcr_props

bind afcr_top afcr_props #(.DATA_W(DATA_W)) afcr_props_i (.sys_clk, .nrst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .ref_below_low, .ref_above_high, .cal_valid, .cal_full_scale,
  .cal_coef, .pos_pin_sel, .neg_pin_sel, .neg_common_sel, .buffer_on, .gain_value,
  .ref_pair_two_as_ref, .ref_pair_two_gpo_en, .burnout_src_on, .burnout_sink_on,
  .offset_coef, .full_coef, .irq);

// ==== tb/afcr_sensor_model.sv ====
// far side model: reference comparators, modulator and calibration results
`timescale 1ns/1ps
module afcr_sensor_model (
  input  wire        sys_clk,
  output reg         ref_below_low,
  output reg         ref_above_high,
  output reg         conv_valid,
  output reg  [23:0] conv_unipolar_code,
  output reg         cal_valid,
  output reg         cal_full_scale,
  output reg  [23:0] cal_coef
);
  initial begin
    {ref_below_low, ref_above_high, conv_valid, cal_valid, cal_full_scale} = 5'h00;
    conv_unipolar_code = 24'h000000;
    cal_coef = 24'h000000;
  end
  task set_ref(input integer lv);
    @(posedge sys_clk);
    ref_below_low  <= (lv == 1);
    ref_above_high <= (lv == 2);
  endtask
  task conv(input logic [23:0] k);
    @(posedge sys_clk);
    conv_valid <= 1'b1;
    conv_unipolar_code <= k;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    // idle word inverted so a stale sample cannot pass
    conv_unipolar_code <= ~k;
  endtask
  task cal(input logic f, input logic [23:0] k);
    @(posedge sys_clk);
    cal_valid <= 1'b1;
    cal_full_scale <= f;
    cal_coef <= k;
    @(posedge sys_clk);
    cal_valid <= 1'b0;
    cal_coef <= ~k;
  endtask
endmodule // afcr_sensor_model

// ==== tb/tb.sv ====
// self-checking bench for afcr_top with a behavioural model
`timescale 1ns/1ps
module tb;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd, cfg;
  logic        se, flag, uni;
  logic [23:0] codes[$], c;
  integer      err_count = 0, tests_run = 0, cyc = 0, i;
  wire  [31:0] prdata;
  wire  [23:0] conv_unipolar_code, cal_coef, offset_coef, full_coef;
  wire  [7:0]  gain_value;
  wire  [3:0]  pos_pin_sel, neg_pin_sel;
  wire         pready, pslverr, ref_below_low, ref_above_high, conv_valid, cal_valid;
  wire         cal_full_scale, neg_common_sel, buffer_on, ref_pair_two_as_ref;
  wire         ref_pair_two_gpo_en, burnout_src_on, burnout_sink_on, irq;
  always #2.5 sys_clk = ~sys_clk;
  afcr_top afcr_top_i (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ref_below_low, .ref_above_high, .conv_valid, .conv_unipolar_code,
    .cal_valid, .cal_full_scale, .cal_coef, .pos_pin_sel, .neg_pin_sel, .neg_common_sel,
    .buffer_on, .gain_value, .ref_pair_two_as_ref, .ref_pair_two_gpo_en, .burnout_src_on,
    .burnout_sink_on, .offset_coef, .full_coef, .irq);
  afcr_sensor_model afcr_sensor_model_i (.sys_clk, .ref_below_low, .ref_above_high,
    .conv_valid, .conv_unipolar_code, .cal_valid, .cal_full_scale, .cal_coef);
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // request held until pready is seen high at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task conv_chk(input logic [23:0] k);
    afcr_sensor_model_i.conv(k);
    apb(1'b0, 12'h00C, 32'h0);
    chk("data", flag ? 32'hFFFFFF : uni ? k : k ^ 24'h800000, rd);
  endtask
  // gain output lags a config write by two edges; sample one edge later
  task settle;
    repeat (3) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    void'($urandom(73552));
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(1'b0, 12'h010, 32'h0);
    chk("offset_rst", 32'h800000, rd);
    apb(1'b0, 12'h0F0, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("slverr", 32'h1, se);
    $display("test reset done");
    apb(1'b1, 12'h018, 32'h1);
    for (i = 0; i < 8; i++) begin
      cfg = ($urandom & 32'h1E3FF) | (i << 10);
      apb(1'b1, 12'h000, cfg);
      settle;
      chk("pins", cfg[8:0], {neg_common_sel, pos_pin_sel, neg_pin_sel});
      chk("buf", cfg[9], buffer_on);
      chk("gain", i < 3 ? 1 : 8 << (i - 3), gain_value);
      chk("reference_select", {cfg[13], !cfg[13]}, {ref_pair_two_as_ref, ref_pair_two_gpo_en});
      chk("burn", {2{cfg[16]}}, {burnout_src_on, burnout_sink_on});
      apb(1'b0, 12'h018, 32'h0);
      chk("route", {15'h0, 1'(i != 1 && i != 2), 8'(i < 3 ? 1 : 8 << (i - 3)), 8'h01}, rd);
    end
    $display("test config done");
    apb(1'b1, 12'h000, 32'h0);
    flag = 1'b0;
    uni = 1'b0;
    afcr_sensor_model_i.set_ref(1);
    settle;
    apb(1'b0, 12'h004, 32'h0);
    chk("flag_off", 32'h0, rd & 32'h3);
    apb(1'b1, 12'h000, 32'h4000);
    flag = 1'b1;
    afcr_sensor_model_i.set_ref(0);
    settle;
    apb(1'b0, 12'h004, 32'h0);
    chk("flag_hold", 32'h1, rd & 32'h3);
    codes = '{24'h000000, 24'h800000, 24'hFFFFFF, 24'h7FFFFF};
    codes.push_back($urandom);
    conv_chk(codes[4]);
    apb(1'b0, 12'h004, 32'h0);
    chk("flag_seen", 32'h1, rd & 32'h1);
    afcr_sensor_model_i.cal(1'b1, $urandom);
    apb(1'b0, 12'h014, 32'h0);
    chk("full_kept", 32'h500000, rd);
    apb(1'b0, 12'h004, 32'h0);
    chk("err", 32'h3, rd & 32'h3);
    afcr_sensor_model_i.set_ref(2);
    flag = 1'b0;
    settle;
    for (i = 0; i < 10; i++) begin
      if (i == 5) begin
        uni = 1'b1;
        apb(1'b1, 12'h000, 32'hC000);
      end
      conv_chk(codes[i % 5]);
    end
    c = $urandom;
    afcr_sensor_model_i.cal(1'b0, c);
    apb(1'b0, 12'h010, 32'h0);
    chk("offset_cal", c, rd);
    $display("test reference and data done");
    apb(1'b1, 12'h008, 32'h2);
    afcr_sensor_model_i.set_ref(1);
    settle;
    afcr_sensor_model_i.cal(1'b0, ~c);
    @(posedge sys_clk);
    chk("irq_set", 32'h1, irq);
    apb(1'b0, 12'h010, 32'h0);
    chk("offset_kept", c, rd);
    apb(1'b0, 12'h004, 32'h0);
    @(posedge sys_clk);
    chk("irq_clr", 32'h0, irq);
    apb(1'b1, 12'h008, 32'h0);
    afcr_sensor_model_i.cal(1'b0, ~c);
    @(posedge sys_clk);
    chk("irq_mask", 32'h0, irq);
    $display("test interrupt done");
    close_out;
  end
endmodule // tb
